// *** src/rax_pkg.sv ***
// package of constants and carrier types for the relay and auxiliary input block
`default_nettype none
package rax_pkg;
  // ----------------------------------------------------------------
  // relay function codes
  // ----------------------------------------------------------------
  localparam logic [2:0] RLY_SYS_FAULT  = 3'h0;
  localparam logic [2:0] RLY_PUMP_FAULT = 3'h4;
  localparam logic [2:0] RLY_MIN_FREQ   = 3'h5;
  localparam logic [2:0] RLY_JOCKEY     = 3'h6;
  localparam logic [2:0] RLY_A_MAX      = 3'h6;
  localparam logic [2:0] RLY_B_MAX      = 3'h5;
  localparam logic [2:0] RLY_RESET      = 3'h0;
  // ----------------------------------------------------------------
  // input function codes
  // ----------------------------------------------------------------
  localparam logic [1:0] IN_RUN_STOP    = 2'h0;
  localparam logic [1:0] IN_ALWAYS_RUN  = 2'h1;
  localparam logic [1:0] IN_LATCH_STOP  = 2'h2;
  localparam logic [1:0] IN_REVERSE     = 2'h3;
  localparam logic [1:0] IN_A_MAX       = 2'h2;
  localparam logic [1:0] IN_B_MAX       = 2'h3;
  localparam logic [1:0] IN_RESET       = 2'h1;
  localparam logic [2:0] SYS_AUX_RUN    = 3'h0;
  localparam logic [2:0] SYS_CFG_MAX    = 3'h4;
  // ----------------------------------------------------------------
  // contrast limits
  // ----------------------------------------------------------------
  localparam logic [5:0] CONTRAST_RESET = 6'h28;
  localparam logic [5:0] CONTRAST_MIN   = 6'h1e;
  localparam logic [5:0] CONTRAST_MAX   = 6'h3f;
  // ----------------------------------------------------------------
  // register map (plain port, word index)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL       = 4'h0;
  localparam logic [3:0] REG_FUNC       = 4'h1;
  localparam logic [3:0] REG_CONTRAST   = 4'h2;
  localparam logic [3:0] REG_STATUS     = 4'h3;
  localparam logic [3:0] REG_CLOCK_LO   = 4'h4;
  localparam logic [3:0] REG_CLOCK_HI   = 4'h5;
  localparam logic [3:0] REG_CURSOR     = 4'h6;
  // ctrl bits
  localparam int CTRL_REVERSE_BIT  = 0;
  localparam int CTRL_LOCKOUT_BIT  = 1;
  localparam int CTRL_LEADLAG_BIT  = 2;
  localparam int CTRL_SYSCFG_LSB   = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
  // debounce
  localparam int DEBOUNCE_NS  = 5000;
  localparam int CLK_NS       = 20;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_NS - 1) / CLK_NS;
  // clock digits: 12 bcd digits MM DD YY HH MM SS
  localparam int CLOCK_DIGITS = 12;
  localparam logic [3:0] CURSOR_LAST = 4'hb;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RAX_OP_OFF  = 2'b00,
    RAX_OP_AUTO = 2'b01,
    RAX_OP_HAND = 2'b10
  } rax_opmode_t;
  typedef struct packed {
    logic sys_fault;
    logic pump_fault;
    logic above_min;
    logic freq_nonzero;
  } rax_cond_t;
  typedef struct packed {
    logic enter;
    logic up;
    logic down;
    logic hand;
    logic auto_key;
    logic off;
  } rax_keys_t;
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rax_bus_t;
endpackage
`default_nettype wire

// *** src/rax_debounce.sv ***
// contact input synchroniser and debounce filter
`default_nettype none
module rax_debounce #(
  parameter int CYCLES = rax_pkg::DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic srst_i,
  // contact
  input  wire logic raw_i,
  output logic      level_o
);
  import rax_pkg::*;
  localparam int CW = $clog2(CYCLES + 1);
  logic          sync1_reg;
  logic          sync2_reg;
  logic [CW-1:0] cnt_reg;
  // two-stage sync; first stage feeds only the second
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= raw_i;
      sync2_reg <= sync1_reg;
    end
  end
  // level accepted only after it holds steady for CYCLES
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cnt_reg <= '0;
      level_o <= 1'b0;
    end else if (sync2_reg == level_o) begin
      cnt_reg <= '0;
    end else if (cnt_reg == CW'(CYCLES - 1)) begin
      cnt_reg <= '0;
      level_o <= sync2_reg;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** src/rax_relay_sel.sv ***
// per-relay condition selector
`default_nettype none
module rax_relay_sel (
  // selection
  input  wire logic [2:0]        func_i,
  input  wire rax_pkg::rax_cond_t cond_i,
  input  wire logic              leadlag_i,
  input  wire logic              leadlag_drive_i,
  // result
  output logic                   close_o
);
  import rax_pkg::*;
  // open is the idle state of a normally open contact
  always_comb begin
    close_o = 1'b0;
    if (leadlag_i && func_i != RLY_JOCKEY) begin
      close_o = leadlag_drive_i;
    end else begin
      unique case (func_i)
        RLY_SYS_FAULT:  close_o = !cond_i.sys_fault;
        RLY_PUMP_FAULT: close_o = !cond_i.pump_fault;
        RLY_MIN_FREQ:   close_o = cond_i.above_min;
        RLY_JOCKEY:     close_o = cond_i.freq_nonzero;
        default:        close_o = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** src/rax_top.sv ***
// relay outputs, run/stop inputs and operator settings of the drive
// Functional notes
// - relay contacts are normally open; close only when selected condition asks
// - code 0: closed in normal operation, open on any system fault
// - codes 1 to 3 are reserved and leave the relay open
// - code 4: closed normally, open on pump fault
// - code 5: closes when motor frequency exceeds minimum threshold
// - lead/lag control owns both relays, overriding every code except 6
// - code 6: closed while frequency above zero; no lead/lag part
// - code 6 only for relay a; relay b limited to 0 through 5
// - analog reverse inverts scale of both analog inputs; default normal
// - manual lockout limits modes to auto or off; default on
// - input code 0: closed contact runs, open contact stops
// - code 1 always runs, default for both; input b accepts 0 to 3
// - input b code 2: opening latches stop fault until enter pressed outside clock edit
// - input b code 3: open circuit reverses motor rotation
// - system configuration may redefine both inputs, overriding codes
// - clock setup edits MM/DD/YY HH:MM:SS; enter moves right, arrows change digit
// - display contrast default 40, range 30 to 63
// - configuration 0: motor runs only when both inputs permit (AND)
`default_nettype none
module rax_top #(
  parameter int AW  = 12,
  parameter int DEB = rax_pkg::DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  srst_i,
  // register port
  input  wire rax_pkg::rax_bus_t     bus_i,
  output logic [31:0]                rdata_o,
  // contacts and keypad
  input  wire logic                  run_input_a_i,
  input  wire logic                  run_input_b_i,
  input  wire rax_pkg::rax_keys_t    keys_i,
  // drive conditions
  input  wire rax_pkg::rax_cond_t    cond_i,
  input  wire logic                  leadlag_drive_a_i,
  input  wire logic                  leadlag_drive_b_i,
  input  wire logic [AW-1:0]         analog_v_i,
  input  wire logic [AW-1:0]         analog_i_i,
  // relay outputs
  output logic                       relay_a_contact_o,
  output logic                       relay_b_contact_o,
  // run control
  output logic                       run_cmd_o,
  output logic                       reverse_o,
  output logic                       latch_fault_o,
  output rax_pkg::rax_opmode_t       opmode_o,
  // scaled analog and display
  output logic [AW-1:0]              analog_v_o,
  output logic [AW-1:0]              analog_i_o,
  output logic [5:0]                 display_contrast_o
);
  import rax_pkg::*;
  // ----------------------------------------------------------------
  // settings registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [2:0]  relay_a_func_reg;
  logic [2:0]  relay_b_func_reg;
  logic [1:0]  input_a_function_reg;
  logic [1:0]  input_b_function_reg;
  logic [3:0]  digit_reg [CLOCK_DIGITS];
  logic [3:0]  cursor_reg;
  logic        clock_edit_reg;
  logic        reverse_en;
  logic        lockout_en;
  logic        leadlag_en;
  logic [2:0]  sys_cfg;
  logic        wr_ctrl;
  logic        wr_func;
  assign reverse_en = ctrl_reg[CTRL_REVERSE_BIT];
  assign lockout_en = ctrl_reg[CTRL_LOCKOUT_BIT];
  assign leadlag_en = ctrl_reg[CTRL_LEADLAG_BIT];
  assign sys_cfg    = ctrl_reg[CTRL_SYSCFG_LSB +: 3];
  assign wr_ctrl    = bus_i.wr && bus_i.addr == REG_CTRL;
  assign wr_func    = bus_i.wr && bus_i.addr == REG_FUNC;

  // control word; out-of-range config is refused so old value stays
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl && bus_i.wdata[CTRL_SYSCFG_LSB +: 3] <= SYS_CFG_MAX) begin
      ctrl_reg <= {25'h0, bus_i.wdata[CTRL_SYSCFG_LSB +: 3], 1'b0, bus_i.wdata[2:0]};
    end
  end

  // function codes; relay a, relay b and input a fields checked against their own ranges
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      relay_a_func_reg     <= RLY_RESET;
      relay_b_func_reg     <= RLY_RESET;
      input_a_function_reg <= IN_RESET;
      input_b_function_reg <= IN_RESET;
    end else if (wr_func) begin
      if (bus_i.wdata[2:0] <= RLY_A_MAX) relay_a_func_reg <= bus_i.wdata[2:0];
      if (bus_i.wdata[6:4] <= RLY_B_MAX) relay_b_func_reg <= bus_i.wdata[6:4];
      if (bus_i.wdata[9:8] <= IN_A_MAX) input_a_function_reg <= bus_i.wdata[9:8];
      input_b_function_reg <= bus_i.wdata[13:12];
    end
  end

  // contrast; writes outside 30..63 ignored
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      display_contrast_o <= CONTRAST_RESET;
    end else if (bus_i.wr && bus_i.addr == REG_CONTRAST &&
                 bus_i.wdata[5:0] >= CONTRAST_MIN && bus_i.wdata[31:6] == 26'h0) begin
      display_contrast_o <= bus_i.wdata[5:0];
    end
  end

  // ----------------------------------------------------------------
  // contact inputs
  // ----------------------------------------------------------------
  logic in_a_closed;
  logic in_b_closed;
  rax_debounce #(.CYCLES(DEB)) u_deb_a (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .raw_i     (run_input_a_i),
    .level_o   (in_a_closed)
  );
  rax_debounce #(.CYCLES(DEB)) u_deb_b (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .raw_i     (run_input_b_i),
    .level_o   (in_b_closed)
  );

  // falling edge of debounced input b for the latch
  logic in_b_prev_reg;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) in_b_prev_reg <= 1'b0;
    else        in_b_prev_reg <= in_b_closed;
  end

  // latched stop fault; a new opening beats a same-cycle enter
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      latch_fault_o <= 1'b0;
    end else if (input_b_function_reg == IN_LATCH_STOP && in_b_prev_reg && !in_b_closed) begin
      latch_fault_o <= 1'b1;
    end else if (keys_i.enter && !clock_edit_reg) begin
      latch_fault_o <= 1'b0;
    end
  end

  // per-input permit
  logic permit_a;
  logic permit_b;
  always_comb begin
    unique case (input_a_function_reg)
      IN_RUN_STOP: permit_a = in_a_closed;
      default:     permit_a = 1'b1;
    endcase
    unique case (input_b_function_reg)
      IN_RUN_STOP:   permit_b = in_b_closed;
      IN_LATCH_STOP: permit_b = !latch_fault_o;
      default:       permit_b = 1'b1;
    endcase
  end

  // outside configuration 0 the contacts become plain run-permits
  // for the pressure loop, so the codes no longer apply
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      run_cmd_o <= 1'b0;
      reverse_o <= 1'b0;
    end else if (sys_cfg == SYS_AUX_RUN) begin
      run_cmd_o <= permit_a && permit_b;
      reverse_o <= input_b_function_reg == IN_REVERSE && !in_b_closed;
    end else begin
      run_cmd_o <= in_a_closed && in_b_closed;
      reverse_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // operating mode and manual lockout
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      opmode_o <= RAX_OP_OFF;
    end else if (lockout_en && opmode_o == RAX_OP_HAND) begin
      opmode_o <= RAX_OP_OFF;
    end else if (keys_i.off) begin
      opmode_o <= RAX_OP_OFF;
    end else if (keys_i.auto_key) begin
      opmode_o <= RAX_OP_AUTO;
    end else if (keys_i.hand && !lockout_en) begin
      opmode_o <= RAX_OP_HAND;
    end
  end

  // ----------------------------------------------------------------
  // analog scale and relays
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      analog_v_o <= '0;
      analog_i_o <= '0;
    end else begin
      analog_v_o <= reverse_en ? ~analog_v_i : analog_v_i;
      analog_i_o <= reverse_en ? ~analog_i_i : analog_i_i;
    end
  end

  logic close_a;
  logic close_b;
  rax_relay_sel u_sel_a (
    .func_i          (relay_a_func_reg),
    .cond_i          (cond_i),
    .leadlag_i       (leadlag_en),
    .leadlag_drive_i (leadlag_drive_a_i),
    .close_o         (close_a)
  );
  rax_relay_sel u_sel_b (
    .func_i          (relay_b_func_reg),
    .cond_i          (cond_i),
    .leadlag_i       (leadlag_en),
    .leadlag_drive_i (leadlag_drive_b_i),
    .close_o         (close_b)
  );
  // registered so contacts never glitch on selector changes
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      relay_a_contact_o <= 1'b0;
      relay_b_contact_o <= 1'b0;
    end else begin
      relay_a_contact_o <= close_a;
      relay_b_contact_o <= close_b;
    end
  end

  // ----------------------------------------------------------------
  // date-time editor
  // ----------------------------------------------------------------
  logic wr_lo;
  logic wr_hi;
  assign wr_lo = bus_i.wr && bus_i.addr == REG_CLOCK_LO;
  assign wr_hi = bus_i.wr && bus_i.addr == REG_CLOCK_HI;

  // edit mode and cursor; enter past the last digit leaves edit mode
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      clock_edit_reg <= 1'b0;
      cursor_reg     <= '0;
    end else if (bus_i.wr && bus_i.addr == REG_CURSOR) begin
      clock_edit_reg <= bus_i.wdata[0];
      cursor_reg     <= '0;
    end else if (clock_edit_reg && keys_i.enter) begin
      if (cursor_reg == CURSOR_LAST) begin
        clock_edit_reg <= 1'b0;
        cursor_reg     <= '0;
      end else begin
        cursor_reg <= cursor_reg + 1'b1;
      end
    end
  end

  // digits, one bcd nibble each; arrows wrap 0..9
  genvar gi;
  generate
    for (gi = 0; gi < CLOCK_DIGITS; gi++) begin : g_digit
      always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
          digit_reg[gi] <= 4'h0;
        end else if (gi < 8 && wr_lo) begin
          digit_reg[gi] <= bus_i.wdata[(gi % 8) * 4 +: 4];
        end else if (gi >= 8 && wr_hi) begin
          digit_reg[gi] <= bus_i.wdata[(gi % 8) * 4 +: 4];
        end else if (clock_edit_reg && cursor_reg == 4'(gi)) begin
          if (keys_i.up)
            digit_reg[gi] <= (digit_reg[gi] >= 4'h9) ? 4'h0 : digit_reg[gi] + 1'b1;
          else if (keys_i.down)
            digit_reg[gi] <= (digit_reg[gi] == 4'h0) ? 4'h9 : digit_reg[gi] - 1'b1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else if (bus_i.rd) begin
      unique case (bus_i.addr)
        REG_CTRL:     rdata_o <= ctrl_reg;
        REG_FUNC:     rdata_o <= {18'h0, input_b_function_reg, 2'h0, input_a_function_reg,
                                  1'b0, relay_b_func_reg, 1'b0, relay_a_func_reg};
        REG_CONTRAST: rdata_o <= {26'h0, display_contrast_o};
        REG_STATUS:   rdata_o <= {22'h0, opmode_o, in_b_closed, in_a_closed,
                                  relay_b_contact_o, relay_a_contact_o,
                                  latch_fault_o, reverse_o, run_cmd_o, 1'b0};
        REG_CLOCK_LO: rdata_o <= {digit_reg[7], digit_reg[6], digit_reg[5], digit_reg[4],
                                  digit_reg[3], digit_reg[2], digit_reg[1], digit_reg[0]};
        REG_CLOCK_HI: rdata_o <= {16'h0, digit_reg[11], digit_reg[10], digit_reg[9],
                                  digit_reg[8]};
        REG_CURSOR:   rdata_o <= {27'h0, cursor_reg, clock_edit_reg};
        default:      rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end
endmodule
`default_nettype wire

// *** tb/rax_field_model.sv ***
// field side model: run contacts and operator keypad
`default_nettype none
module rax_field_model import rax_pkg::*; (
  // clock
  input  wire logic       clk_sys_i,
  // bench requests
  input  wire logic       a_i,
  input  wire logic       b_i,
  input  wire rax_keys_t  key_i,
  // pins toward the drive
  output logic            run_input_a_o,
  output logic            run_input_b_o,
  output rax_keys_t       keys_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins follow one edge later
  always_ff @(posedge clk_sys_i) begin
    run_input_a_o <= a_i;
    run_input_b_o <= b_i;
    keys_o        <= key_i;
  end
endmodule
`default_nettype wire

// *** tb/rax_monitor.sv ***
// checker of relay, run and setting behaviour at the top ports
`default_nettype none
module rax_monitor import rax_pkg::*; #(
  parameter int AW = 12
) (
  // clock, reset and bus
  input  wire logic           clk_sys_i,
  input  wire logic           srst_i,
  input  wire rax_bus_t       bus_i,
  // drive conditions
  input  wire rax_cond_t      cond_i,
  input  wire logic           leadlag_drive_a_i,
  input  wire logic           leadlag_drive_b_i,
  input  wire logic [AW-1:0]  analog_v_i,
  input  wire logic [AW-1:0]  analog_i_i,
  // outputs watched
  input  wire logic           relay_a_contact_o,
  input  wire logic           relay_b_contact_o,
  input  wire logic           run_cmd_o,
  input  wire logic           reverse_o,
  input  wire logic           latch_fault_o,
  input  wire rax_opmode_t    opmode_o,
  input  wire logic [AW-1:0]  analog_v_o,
  input  wire logic [AW-1:0]  analog_i_o,
  input  wire logic [5:0]     display_contrast_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb_mon @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  logic [2:0] ra_q, rb_q, cfg_q;
  logic [1:0] ib_q;
  logic       ll_q, lock_q, rev_q, exp_a, exp_b, con_ok, con_wr;
  // relay choice; lead/lag wins except jockey
  function automatic logic sel(logic [2:0] c, logic l, logic d, rax_cond_t k);
    if (l && c != RLY_JOCKEY) return d;
    case (c)
      RLY_SYS_FAULT:  return !k.sys_fault;
      RLY_PUMP_FAULT: return !k.pump_fault;
      RLY_MIN_FREQ:   return k.above_min;
      RLY_JOCKEY:     return k.freq_nonzero;
      default:        return 1'b0;
    endcase
  endfunction
  assign exp_a = sel(ra_q, ll_q, leadlag_drive_a_i, cond_i);
  assign exp_b = sel(rb_q, ll_q, leadlag_drive_b_i, cond_i);
  assign con_wr = bus_i.wr && bus_i.addr == REG_CONTRAST;
  assign con_ok = bus_i.wdata >= 32'(CONTRAST_MIN) && bus_i.wdata <= 32'(CONTRAST_MAX);
  // function shadow; out of range fields kept
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      {ra_q, rb_q, ib_q} <= {RLY_RESET, RLY_RESET, IN_RESET};
    end else if (bus_i.wr && bus_i.addr == REG_FUNC) begin
      if (bus_i.wdata[2:0] <= RLY_A_MAX) ra_q <= bus_i.wdata[2:0];
      if (bus_i.wdata[6:4] <= RLY_B_MAX) rb_q <= bus_i.wdata[6:4];
      ib_q <= bus_i.wdata[13:12];
    end
  end
  // control shadow; bad config drops the write
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      {cfg_q, ll_q, lock_q, rev_q} <= 6'h02;
    end else if (bus_i.wr && bus_i.addr == REG_CTRL && bus_i.wdata[6:4] <= SYS_CFG_MAX) begin
      {cfg_q, ll_q, lock_q, rev_q} <= {bus_i.wdata[6:4], bus_i.wdata[2:0]};
    end
  end
  AST_CONTRAST_RESET: assert property ($fell(srst_i) |->
    display_contrast_o == CONTRAST_RESET) else $error("contrast reset");
  AST_CONTRAST_WRITE: assert property (con_wr |=> display_contrast_o ==
    $past(con_ok ? bus_i.wdata[5:0] : display_contrast_o)) else $error("contrast write");
  AST_RELAY_A: assert property (!$past(srst_i) |->
    relay_a_contact_o == $past(exp_a)) else $error("relay a wrong");
  AST_RELAY_B: assert property (!$past(srst_i) |->
    relay_b_contact_o == $past(exp_b)) else $error("relay b wrong");
  AST_NO_HAND: assert property ($past(lock_q) && lock_q |->
    opmode_o != RAX_OP_HAND) else $error("hand while locked");
  AST_ANALOG: assert property (!$past(srst_i) |->
    analog_v_o == $past(analog_v_i ^ {AW{rev_q}}) &&
    analog_i_o == $past(analog_i_i ^ {AW{rev_q}})) else $error("analog scale");
  AST_REVERSE_CODE: assert property (reverse_o |->
    $past(ib_q) == IN_REVERSE && $past(cfg_q) == SYS_AUX_RUN) else $error("stray reverse");
  AST_LATCH_STOPS: assert property ($past(latch_fault_o) &&
    $past(ib_q) == IN_LATCH_STOP && $past(cfg_q) == SYS_AUX_RUN |-> !run_cmd_o)
    else $error("run while latched");
endmodule
bind rax_top rax_monitor #(.AW(AW)) i_mon (
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .bus_i(bus_i), .cond_i(cond_i),
  .leadlag_drive_a_i(leadlag_drive_a_i), .leadlag_drive_b_i(leadlag_drive_b_i),
  .analog_v_i(analog_v_i), .analog_i_i(analog_i_i), .run_cmd_o(run_cmd_o),
  .relay_a_contact_o(relay_a_contact_o), .relay_b_contact_o(relay_b_contact_o),
  .reverse_o(reverse_o), .latch_fault_o(latch_fault_o), .opmode_o(opmode_o),
  .analog_v_o(analog_v_o), .analog_i_o(analog_i_o),
  .display_contrast_o(display_contrast_o));
`default_nettype wire

// *** tb/test_relay_aux_io_config.sv ***
// bench of relay outputs, run inputs and operator settings
`default_nettype none
module test_relay_aux_io_config import rax_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [2:0] c; rax_cond_t k; logic ea; logic eb;} rax_row_t;
  logic         clk_sys_i, srst_i, ca, cb, lla, llb, rin_a, rin_b, rla, rlb, run, rev, lat;
  rax_bus_t     bus;
  rax_keys_t    key, keys;
  rax_cond_t    cond;
  rax_opmode_t  opm;
  logic [11:0]  av, ai, avo, aio;
  logic [31:0]  rdata, d;
  logic [5:0]   con;
  int           fails = 0, check_count = 0, cyc_n = 0;
  // relay rows: code, conditions, expected a and b
  rax_row_t rows [12] = '{9'h003, 9'h020, 9'h040, 9'h0bc, 9'h0c0, 9'h103,
                          9'h110, 9'h14b, 9'h174, 9'h186, 9'h1b9, 9'h1c6};
  logic [31:0] cw [4] = '{32'h1e, 32'h1d, 32'h3f, 32'h40};
  logic [31:0] ce [4] = '{32'h1e, 32'h1e, 32'h3f, 32'h3f};
  rax_top #(.AW(12), .DEB(4)) i_dut (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .bus_i(bus), .rdata_o(rdata),
    .run_input_a_i(rin_a), .run_input_b_i(rin_b), .keys_i(keys), .cond_i(cond),
    .leadlag_drive_a_i(lla), .leadlag_drive_b_i(llb), .analog_v_i(av),
    .analog_i_i(ai), .relay_a_contact_o(rla), .relay_b_contact_o(rlb),
    .run_cmd_o(run), .reverse_o(rev), .latch_fault_o(lat), .opmode_o(opm),
    .analog_v_o(avo), .analog_i_o(aio), .display_contrast_o(con));
  rax_field_model i_fld (.clk_sys_i(clk_sys_i), .a_i(ca), .b_i(cb), .key_i(key),
    .run_input_a_o(rin_a), .run_input_b_o(rin_b), .keys_o(keys));
  // --------
  // tasks
  // --------
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_word(n, {31'h0, e}, {31'h0, g});
  endtask
  // n edges, then mid-cycle
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_sys_i);
    bus.wr <= 1'b0;
  endtask
  // read data stands one cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys_i);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys_i);
    bus.rd <= 1'b0;
    @(negedge clk_sys_i);
    v = rdata;
  endtask
  task automatic press(input rax_keys_t k);
    @(posedge clk_sys_i);
    key <= k;
    @(posedge clk_sys_i);
    key <= '0;
    wait_n(2);
  endtask
  // filter time plus model and output stages
  task automatic set_c(input logic a, input logic b);
    @(posedge clk_sys_i);
    ca <= a;
    cb <= b;
    wait_n(14);
  endtask
  // clock and hang limit; run needs under 5000 cycles
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      fails++;
      test_done();
    end
  end
  // --------
  // main sequence
  // --------
  initial begin
    {srst_i, ca, cb, lla, llb} = 5'h18;
    {bus, key, cond} = '0;
    av = 12'h123;
    ai = 12'h0f0;
    wait_n(3);
    chk_bit("relay a reset", 1'b0, rla);
    chk_word("contrast reset", 32'h28, 32'(con));
    @(posedge clk_sys_i);
    srst_i <= 1'b0;
    wait_n(2);
    chk_word("analog v", 32'h123, 32'(avo));
    foreach (rows[r]) begin
      wr(REG_FUNC, 32'h1100 | {25'h0, rows[r].c, 1'b0, rows[r].c});
      cond <= rows[r].k;
      wait_n(2);
      chk_bit("relay a", rows[r].ea, rla);
      chk_bit("relay b", rows[r].eb, rlb);
    end
    wr(REG_FUNC, 32'h1100);
    wr(REG_CTRL, 32'h6);
    cond <= 4'h8;
    lla <= 1'b1;
    wait_n(2);
    chk_bit("leadlag a", 1'b1, rla);
    chk_bit("leadlag b", 1'b0, rlb);
    wr(REG_FUNC, 32'h1106);
    llb <= 1'b1;
    wait_n(2);
    chk_bit("jockey a", 1'b0, rla);
    chk_bit("leadlag b", 1'b1, rlb);
    wr(REG_CTRL, 32'h2);
    for (int i = 0; i < 4; i++) begin
      wr(REG_CONTRAST, cw[i]);
      rd(REG_CONTRAST, d);
      chk_word("contrast", ce[i], d);
    end
    rd(4'hf, d);
    chk_word("unmapped", 32'h0, d);
    wr(REG_CTRL, 32'h3);
    wait_n(2);
    chk_word("analog v rev", 32'hedc, 32'(avo));
    chk_word("analog i rev", 32'hf0f, 32'(aio));
    wr(REG_CTRL, 32'h2);
    wr(REG_CTRL, 32'h51);
    wait_n(2);
    chk_word("analog v", 32'h123, 32'(avo));
    press(6'h04);
    chk_word("mode locked", 32'(RAX_OP_OFF), 32'(opm));
    press(6'h02);
    chk_word("mode auto", 32'(RAX_OP_AUTO), 32'(opm));
    wr(REG_CTRL, 32'h0);
    press(6'h04);
    chk_word("mode hand", 32'(RAX_OP_HAND), 32'(opm));
    wr(REG_CTRL, 32'h2);
    wait_n(2);
    chk_word("mode forced off", 32'(RAX_OP_OFF), 32'(opm));
    // clock edit: up twice, right, down wraps
    wr(REG_CLOCK_LO, 32'h0);
    wr(REG_CURSOR, 32'h1);
    press(6'h10);
    press(6'h10);
    press(6'h20);
    press(6'h08);
    rd(REG_CLOCK_LO, d);
    chk_word("clock digits", 32'h92, d);
    rd(REG_CURSOR, d);
    chk_word("cursor", 32'h3, d);
    repeat (11) press(6'h20);
    rd(REG_CURSOR, d);
    chk_bit("edit mode", 1'b0, d[0]);
    wr(REG_FUNC, 32'h0);
    set_c(1'b1, 1'b1);
    chk_bit("run both", 1'b1, run);
    set_c(1'b0, 1'b1);
    chk_bit("run a open", 1'b0, run);
    set_c(1'b1, 1'b0);
    chk_bit("run b open", 1'b0, run);
    set_c(1'b1, 1'b1);
    @(posedge clk_sys_i);
    ca <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    ca <= 1'b1;
    repeat (12) begin
      @(negedge clk_sys_i);
      chk_bit("run bounce", 1'b1, run);
    end
    wr(REG_FUNC, 32'h1100);
    set_c(1'b0, 1'b0);
    chk_bit("run always", 1'b1, run);
    wr(REG_FUNC, 32'h2100);
    set_c(1'b1, 1'b1);
    set_c(1'b1, 1'b0);
    chk_bit("latch set", 1'b1, lat);
    set_c(1'b1, 1'b1);
    chk_bit("latch held", 1'b1, lat);
    chk_bit("run latched", 1'b0, run);
    press(6'h20);
    chk_bit("latch clear", 1'b0, lat);
    chk_bit("run after clear", 1'b1, run);
    wr(REG_FUNC, 32'h3100);
    set_c(1'b1, 1'b0);
    chk_bit("reverse", 1'b1, rev);
    wr(REG_CTRL, 32'h12);
    wait_n(3);
    chk_bit("cfg run", 1'b0, run);
    chk_bit("cfg reverse", 1'b0, rev);
    @(posedge clk_sys_i);
    srst_i <= 1'b1;
    @(posedge clk_sys_i);
    srst_i <= 1'b0;
    wait_n(1);
    chk_word("contrast rereset", 32'h28, 32'(con));
    test_done();
  end
endmodule
`default_nettype wire
